// File: csd_regs.sv
// Purpose: status detail and control register bank of the charger
// Assumes: an upstream serial target decodes frames into index/strobe pulses
// Notes: detail registers are live snapshots; control holds two bits
`timescale 1ns/1ns
`include "csd_defs.svh"
module csd_regs
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 standby_supply,
	input  wire logic                 safeout_power_good,
	input  wire csd_pkg::csd_analog_t analog_in,
	input  wire logic [7:0]           reg_index,
	input  wire logic                 reg_read,
	input  wire logic                 reg_write,
	input  wire logic [7:0]           reg_wdata,
	output logic [7:0]                reg_rdata,
	output logic                      input_monitor_disable,
	output logic                      usb_standby_request,
	output logic                      charger_suspended_summary,
	output logic                      battery_problem_summary
);
	csd_pkg::csd_analog_t   sync_analog;
	csd_pkg::csd_analog_t   supply_async;
	csd_pkg::csd_analog_t   supply_sync;
	csd_pkg::csd_status_t   status;
	csd_pkg::csd_reg_state_t state_ff;
	csd_pkg::csd_reg_state_t nxt_state;
	logic                   stby_ok;
	logic                   pok_now;
	logic                   bank_reset;

	// supply pins enter inverted so the synchroniser's zero reset equals their idle level;
	// otherwise release of rst_n would look like standby loss and a power-good rising edge
	always_comb
	begin
		supply_async = '0;
		supply_async.input_valid = !standby_supply;
		supply_async.charge_enable = !safeout_power_good;
	end

	csd_sync u_sync_analog
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (analog_in),
		.sync_out (sync_analog)
	);

	csd_sync u_sync_supply
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (supply_async),
		.sync_out (supply_sync)
	);

	csd_status_enc u_enc
	(
		.a  (sync_analog),
		.st (status)
	);

	assign stby_ok = !supply_sync.input_valid;
	assign pok_now = !supply_sync.charge_enable;
	// reset on standby loss or power-good rising edge
	assign bank_reset = !stby_ok || (pok_now && !state_ff.pok_last);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.pok_last = pok_now;
		if (bank_reset)
			nxt_state.ctrl = `CSD_CTRL_RESET;
		else if (reg_write && reg_index == `CSD_IDX_CONTROL)
			nxt_state.ctrl = reg_wdata & `CSD_CTRL_MASK;
		// writes to the detail indices fall through untouched
		if (reg_read)
		begin
			unique case (reg_index)
				`CSD_IDX_INPUT_THERMAL: nxt_state.rdata = status.input_thermal;
				`CSD_IDX_BATT_CHARGER:  nxt_state.rdata = status.battery_charger;
				`CSD_IDX_CONTROL:       nxt_state.rdata = state_ff.ctrl;
				default:           nxt_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			// treated as already high: a power good present through reset is no new edge
			state_ff.pok_last <= 1'b1;
			state_ff.ctrl     <= `CSD_CTRL_RESET;
			state_ff.rdata    <= 8'h00;
		end
		else
			state_ff <= nxt_state;
	end

	assign reg_rdata                 = state_ff.rdata;
	assign input_monitor_disable     = state_ff.ctrl[`CSD_BIT_MON_DIS];
	assign usb_standby_request       = state_ff.ctrl[`CSD_BIT_USB_STANDBY];
	assign charger_suspended_summary = status.suspended;
	assign battery_problem_summary   = status.battery_problem;
endmodule : csd_regs

// File: csd_defs.svh
// Purpose: constants for the charger status detail register bank
// Assumes: 8-bit registers reached by index over the serial link
// Notes: every offset, control bit position and status code lives here
//
// What this block does
// - input invalid bit reads 0 above 4.5V valid, 1 when invalid
// - current-limited bit reads 1 while input limit holds the current
// - overvoltage bit reads 1 above overvoltage threshold, else 0
// - input-above-battery bit reads 1 when input exceeds battery voltage
// - thermistor band 001 cold suspended, 101 hot suspended
// - thermistor band 010 cool charging, 011 normal charging
// - thermistor band 100 warm charging continues
// - battery field 00 below 2.1V, phase field 0000 with it unless phase is 1000
// - battery field 10 for healthy battery
// - battery field 11 on battery overvoltage, only with valid input
// - phase codes 0000 dead to 0100 top-off
// - phase 0101 done, 0110 timer fault, 0111 temperature suspend
// - phase 1000 when input invalid or charging disabled
// - phase 1001 when charging with die thermal loop active
// - input monitor disable stops input voltage monitoring, resets 0
// - usb standby request selects low-current standby, resets 0
// - standby supply loss or power-good rising edge resets the control bits
// - suspended summary is 1 exactly for phases 0101 to 1000
// - battery problem summary is 1 for battery field 01 or 11
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

`define CSD_IDX_INPUT_THERMAL 8'h03
`define CSD_IDX_BATT_CHARGER  8'h04
`define CSD_IDX_CONTROL       8'h05
`define CSD_CTRL_RESET        8'h00
`define CSD_CTRL_MASK         8'h03
`define CSD_BIT_MON_DIS       1
`define CSD_BIT_USB_STANDBY   0

`define CSD_THM_COLD          3'h1
`define CSD_THM_COOL          3'h2
`define CSD_THM_NORMAL        3'h3
`define CSD_THM_WARM          3'h4
`define CSD_THM_HOT           3'h5

`define CSD_BAT_LOW           2'h0
`define CSD_BAT_TIMER         2'h1
`define CSD_BAT_HEALTHY       2'h2
`define CSD_BAT_OVER          2'h3

`define CSD_PH_DEAD           4'h0
`define CSD_PH_PREQUAL        4'h1
`define CSD_PH_FAST_CC        4'h2
`define CSD_PH_FAST_CV        4'h3
`define CSD_PH_TOPOFF         4'h4
`define CSD_PH_DONE           4'h5
`define CSD_PH_TIMER_FAULT    4'h6
`define CSD_PH_TEMP_SUSPEND   4'h7
`define CSD_PH_OFF            4'h8
`define CSD_PH_THERMAL_LOOP   4'h9

`endif

// File: csd_pkg.sv
// Purpose: types of the charger status detail register bank
// Assumes: csd_defs.svh holds the numbers
// Notes: analog comparator results arrive as one struct
package csd_pkg;

	typedef enum logic [2:0]
	{
		CSD_TEMP_COLD,
		CSD_TEMP_COOL,
		CSD_TEMP_NORMAL,
		CSD_TEMP_WARM,
		CSD_TEMP_HOT
	} csd_temp_t;

	typedef enum logic [2:0]
	{
		CSD_CHG_PREQUAL,
		CSD_CHG_FAST_CC,
		CSD_CHG_FAST_CV,
		CSD_CHG_TOPOFF,
		CSD_CHG_DONE
	} csd_chg_t;

	// raw comparator and charger core status, asynchronous to clk
	typedef struct packed {
		logic      input_valid;
		logic      input_current_limited;
		logic      input_overvoltage;
		logic      input_above_battery;
		logic      cold;
		logic      cool;
		logic      warm;
		logic      hot;
		logic      battery_dead;
		logic      safety_timer_expired;
		logic      battery_over;
		logic      charge_enable;
		logic      die_loop_active;
		logic [2:0] core_phase;
	} csd_analog_t;

	typedef struct packed {
		logic [7:0] input_thermal;
		logic [7:0] battery_charger;
		logic       suspended;
		logic       battery_problem;
	} csd_status_t;

	typedef struct packed {
		csd_analog_t s1;
		csd_analog_t s2;
	} csd_sync_state_t;

	typedef struct packed {
		logic       pok_last;
		logic [7:0] ctrl;
		logic [7:0] rdata;
	} csd_reg_state_t;

endpackage : csd_pkg

// File: csd_sync.sv
// Purpose: two-flop synchroniser for the asynchronous status inputs
// Assumes: inputs are quasi-static levels
// Notes: the first stage is read only by the second
`timescale 1ns/1ns
module csd_sync
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire csd_pkg::csd_analog_t async_in,
	output csd_pkg::csd_analog_t      sync_out
);
	csd_pkg::csd_sync_state_t state_ff;
	csd_pkg::csd_sync_state_t nxt_state;

	always_comb
	begin
		nxt_state.s1 = async_in;
		nxt_state.s2 = state_ff.s1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign sync_out = state_ff.s2;
endmodule : csd_sync

// File: csd_status_enc.sv
// Purpose: encode synchronised charger status into detail fields
// Assumes: inputs already synchronised to clk
// Notes: purely combinational; the bank registers the detail bytes, not the summaries
`timescale 1ns/1ns
`include "csd_defs.svh"
module csd_status_enc
(
	input  wire csd_pkg::csd_analog_t a,
	output csd_pkg::csd_status_t      st
);
	logic [2:0] thm;
	logic [1:0] bat;
	logic [3:0] ph;
	logic       temp_stop;

	always_comb
	begin
		temp_stop = a.cold | a.hot;
		if (a.cold)
			thm = `CSD_THM_COLD;
		else if (a.hot)
			thm = `CSD_THM_HOT;
		else if (a.cool)
			thm = `CSD_THM_COOL;
		else if (a.warm)
			thm = `CSD_THM_WARM;
		else
			thm = `CSD_THM_NORMAL;

		// battery overvoltage flag needs a valid input to exist at all
		if (a.battery_dead)
			bat = `CSD_BAT_LOW;
		else if (a.safety_timer_expired)
			bat = `CSD_BAT_TIMER;
		else if (a.battery_over && a.input_valid)
			bat = `CSD_BAT_OVER;
		else
			bat = `CSD_BAT_HEALTHY;

		// off wins, then dead battery, then faults, then active phases
		if (!a.input_valid || !a.charge_enable)
			ph = `CSD_PH_OFF;
		else if (a.battery_dead)
			ph = `CSD_PH_DEAD;
		else if (a.safety_timer_expired)
			ph = `CSD_PH_TIMER_FAULT;
		else if (temp_stop)
			ph = `CSD_PH_TEMP_SUSPEND;
		else if (a.core_phase == csd_pkg::CSD_CHG_DONE)
			ph = `CSD_PH_DONE;
		else if (a.die_loop_active)
			ph = `CSD_PH_THERMAL_LOOP;
		else
		begin
			unique case (a.core_phase)
				csd_pkg::CSD_CHG_PREQUAL: ph = `CSD_PH_PREQUAL;
				csd_pkg::CSD_CHG_FAST_CC: ph = `CSD_PH_FAST_CC;
				csd_pkg::CSD_CHG_FAST_CV: ph = `CSD_PH_FAST_CV;
				csd_pkg::CSD_CHG_TOPOFF:  ph = `CSD_PH_TOPOFF;
				default:                  ph = `CSD_PH_PREQUAL;
			endcase
		end

		st.input_thermal = {~a.input_valid, a.input_current_limited,
		               a.input_overvoltage, a.input_above_battery,
		               1'b0, thm};
		st.battery_charger = {2'b00, bat, ph};
		st.suspended = (ph >= `CSD_PH_DONE) && (ph <= `CSD_PH_OFF);
		st.battery_problem = (bat == `CSD_BAT_TIMER) || (bat == `CSD_BAT_OVER);
	end
endmodule : csd_status_enc

// File: csd_host.sv
// Purpose: host model issuing register strobes to the bank
// Assumes: strobes change at the falling edge
// Notes: released lines show inverted values so stale data is never seen
`timescale 1ns/1ns
module csd_host
(
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic [7:0]      reg_index,
	output logic            reg_read,
	output logic            reg_write,
	output logic [7:0]      reg_wdata
);
	initial
	begin
		reg_index = 8'h00;
		reg_read  = 1'b0;
		reg_write = 1'b0;
		reg_wdata = 8'h00;
	end
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		@(negedge clk);
		reg_index = idx;
		reg_wdata = wd;
		reg_read  = !wr;
		reg_write = wr;
		@(negedge clk);
		reg_read  = 1'b0;
		reg_write = 1'b0;
		reg_index = ~idx;
		reg_wdata = ~wd;
		rd        = reg_rdata;
	endtask : xfer
endmodule : csd_host

// File: csd_regs_asserts.sv
// Purpose: port checks of the status register bank
// Assumes: bound to csd_regs
// Notes: quiet windows cover the bank reset sync delay
`timescale 1ns/1ns
module csd_regs_asserts
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       standby_supply,
	input wire logic       safeout_power_good,
	input wire logic [7:0] reg_index,
	input wire logic       reg_read,
	input wire logic       reg_write,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       input_monitor_disable,
	input wire logic       usb_standby_request,
	input wire logic       charger_suspended_summary,
	input wire logic       battery_problem_summary
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_quiet;
		(standby_supply && $stable(safeout_power_good))[*5];
	endsequence
	sequence s_rd2;
		reg_read && reg_index == 8'h04;
	endsequence
	AST_CTRL_WR: assert property (s_quiet ##0 (reg_write && reg_index == 8'h05) |=>
		{input_monitor_disable, usb_standby_request} == $past(reg_wdata[1:0])) else $error("control write lost");
	AST_CTRL_HOLD: assert property (s_quiet ##0 !(reg_write && reg_index == 8'h05) |=>
		$stable({input_monitor_disable, usb_standby_request})) else $error("control changed");
	AST_CTRL_RD: assert property (reg_read && reg_index == 8'h05 |=>
		reg_rdata == {6'h00, $past(input_monitor_disable), $past(usb_standby_request)}) else $error("control read");
	AST_BAD_RD: assert property (reg_read && !(reg_index inside {[8'h03:8'h05]}) |=>
		reg_rdata == 8'h00) else $error("unmapped read");
	AST_RD_HOLD: assert property (s_quiet ##0 !reg_read |=> $stable(reg_rdata)) else $error("read data moved");
	AST_SUSP: assert property (s_rd2 |=> (reg_rdata[3:0] inside {[4'h5:4'h8]}) ==
		$past(charger_suspended_summary)) else $error("suspended summary");
	AST_BPROB: assert property (s_rd2 |=> reg_rdata[4] == $past(battery_problem_summary)) else
		$error("battery summary");
	AST_RSVD: assert property (reg_read && reg_index == 8'h03 |=> !reg_rdata[3]) else $error("reserved bit");
	AST_PAIR: assert property (s_rd2 |=> (reg_rdata[3:0] != 4'h0 || reg_rdata[5:4] == 2'h0) &&
		(reg_rdata[3:0] != 4'h6 || reg_rdata[5:4] == 2'h1) && reg_rdata[7:6] == 2'h0) else $error("detail pair");
	AST_BANK_RST: assert property ((!standby_supply)[*5] |->
		!input_monitor_disable && !usb_standby_request) else $error("bank reset");
	cover property (reg_write && reg_index == 8'h05 && reg_wdata[1:0] == 2'h3);
	cover property (charger_suspended_summary && battery_problem_summary);
	cover property ($rose(safeout_power_good));
endmodule : csd_regs_asserts
bind csd_regs csd_regs_asserts u_chk (.clk, .rst_n, .standby_supply, .safeout_power_good, .reg_index,
	.reg_read, .reg_write, .reg_wdata, .reg_rdata, .input_monitor_disable, .usb_standby_request,
	.charger_suspended_summary, .battery_problem_summary);

// File: tb_charger_status_detail_regs.sv
// Purpose: self-checking bench of the status register bank
// Assumes: status inputs settle well before each read
// Notes: random status words; core phase kept to legal codes
`timescale 1ns/1ns
module tb_charger_status_detail_regs;
	logic                 clk;
	logic                 rst_n;
	logic                 standby_supply;
	logic                 safeout_power_good;
	csd_pkg::csd_analog_t analog_in;
	logic [7:0]           reg_index;
	logic                 reg_read;
	logic                 reg_write;
	logic [7:0]           reg_wdata;
	logic [7:0]           reg_rdata;
	logic                 input_monitor_disable;
	logic                 usb_standby_request;
	logic                 charger_suspended_summary;
	logic                 battery_problem_summary;
	logic [7:0]           got;
	logic [7:0]           w;
	logic [7:0]           idx;
	logic [7:0]           e2;
	logic [7:0]           ctrl = 8'h00;
	int                   fails = 0;
	int                   compares = 0;
	int                   cycles = 0;
	csd_regs DUT (.clk, .rst_n, .standby_supply, .safeout_power_good, .analog_in, .reg_index, .reg_read,
		.reg_write, .reg_wdata, .reg_rdata, .input_monitor_disable, .usb_standby_request,
		.charger_suspended_summary, .battery_problem_summary);
	csd_host host (.clk, .reg_rdata, .reg_index, .reg_read, .reg_write, .reg_wdata);
	function automatic logic [7:0] exp_d1(csd_pkg::csd_analog_t a);
		logic [2:0] t;
		t = a.cold ? 3'h1 : a.hot ? 3'h5 : a.cool ? 3'h2 : a.warm ? 3'h4 : 3'h3;
		return {!a.input_valid, a.input_current_limited, a.input_overvoltage, a.input_above_battery, 1'b0, t};
	endfunction : exp_d1
	function automatic logic [7:0] exp_d2(csd_pkg::csd_analog_t a);
		logic [1:0] b;
		logic [3:0] p;
		b = a.battery_dead ? 2'h0 : a.safety_timer_expired ? 2'h1 : (a.battery_over && a.input_valid) ? 2'h3 : 2'h2;
		p = (!a.input_valid || !a.charge_enable) ? 4'h8 : a.battery_dead ? 4'h0 : a.safety_timer_expired ? 4'h6
			: (a.cold || a.hot) ? 4'h7 : a.core_phase == 3'h4 ? 4'h5 : a.die_loop_active ? 4'h9
			: 4'(a.core_phase) + 4'h1;
		return {2'h0, b, p};
	endfunction : exp_d2
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic finish_test();
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ceiling sized well above the roughly 1550 cycles the tests need
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails++;
			finish_test();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		standby_supply = 1'b1;
		safeout_power_good = 1'b1;
		analog_in = '0;
		void'($urandom(32'hfda01040));
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		host.xfer(1'b0, 8'h05, 8'h00, got);
		chk("control reset", 8'h00, got);
		for (int i = 0; i < 150; i++)
		begin
			idx = (i % 4 == 3) ? (8'($urandom) | 8'h08) : 8'h03 + 8'(i % 4);
			w = 8'($urandom);
			host.xfer(1'b1, idx, w, got);
			if (idx == 8'h05)
				ctrl = w & 8'h03;
			if (idx > 8'h04)
			begin
				host.xfer(1'b0, idx, 8'h00, got);
				chk("control or unmapped", (idx == 8'h05) ? ctrl : 8'h00, got);
				chk("control pins", ctrl, {6'h00, input_monitor_disable, usb_standby_request});
			end
			analog_in = 16'($urandom);
			analog_in.core_phase = 3'($urandom % 5);
			analog_in.input_valid |= i[0];
			analog_in.charge_enable |= i[0];
			repeat (3) @(negedge clk);
			e2 = exp_d2(analog_in);
			host.xfer(1'b0, 8'h03, 8'h00, got);
			chk("input thermal", exp_d1(analog_in), got);
			host.xfer(1'b0, 8'h04, 8'h00, got);
			chk("battery charger", e2, got);
			chk("suspended", {7'h00, e2[3:0] inside {[4'h5:4'h8]}}, {7'h00, charger_suspended_summary});
			chk("battery problem", {7'h00, e2[4]}, {7'h00, battery_problem_summary});
		end
		for (int k = 0; k < 2; k++)
		begin
			host.xfer(1'b1, 8'h05, 8'h03, got);
			if (k == 0)
				standby_supply = 1'b0;
			else
				safeout_power_good = 1'b0;
			repeat (6) @(negedge clk);
			if (k == 1)
			begin
				// only the rising edge of power good clears the bank, not its fall
				host.xfer(1'b0, 8'h05, 8'h00, got);
				chk("control through power good fall", 8'h03, got);
			end
			standby_supply = 1'b1;
			safeout_power_good = 1'b1;
			repeat (6) @(negedge clk);
			host.xfer(1'b0, 8'h05, 8'h00, got);
			chk("control after bank reset", 8'h00, got);
			chk("control pins after bank reset", 8'h00, {6'h00, input_monitor_disable, usb_standby_request});
		end
		finish_test();
	end
endmodule : tb_charger_status_detail_regs
